// File: src/iwfd_pkg.sv
// Purpose: Shared constants and types for the I/O window forward decoder
// Assumes: Configuration offsets are byte addresses within the bridge header
// Notes:   Dword selection uses offset bits [7:2], byte lane uses bits [1:0]
package iwfd_pkg;

   // ***************************************************************
   // Configuration offsets
   // ***************************************************************
   localparam logic [7:0]  IWFD_OFF_BASE_LOW   = 8'h1C;
   localparam logic [7:0]  IWFD_OFF_LIMIT_LOW  = 8'h1D;
   localparam logic [7:0]  IWFD_OFF_BASE_HIGH  = 8'h30;
   localparam logic [7:0]  IWFD_OFF_LIMIT_HIGH = 8'h32;

   // ***************************************************************
   // Field layout and reset values
   // ***************************************************************
   localparam logic [3:0]  IWFD_IO32_CODE      = 4'h1;      // Low nibble: 32-bit I/O decode
   localparam logic [11:0] IWFD_BASE_LOW_BITS  = 12'h000;   // Implied base bits [11:0]
   localparam logic [11:0] IWFD_LIMIT_LOW_BITS = 12'hFFF;   // Implied limit bits [11:0]
   localparam logic [31:0] IWFD_BASE_RST       = 32'h0000_0000;
   localparam logic [31:0] IWFD_LIMIT_RST      = 32'h0000_0FFF;
   localparam logic [15:0] IWFD_ISA_SEG_HIGH   = 16'h0000;  // Address [31:16] of first 64 kB
   localparam logic [1:0]  IWFD_ISA_LOW_QUAD   = 2'h0;      // Address [9:8] of bottom 256 bytes

   // ***************************************************************
   // Decision carrier
   // ***************************************************************
   typedef struct packed {
      logic        fwd;   // Transaction is forwarded across the bridge
      logic [31:0] addr;  // Address, passed through unchanged
   } iwfd_dec_t;

endpackage : iwfd_pkg

// File: src/iwfd_decode.sv
// Purpose: I/O window decode for downstream and upstream forwarding of a transparent bridge
// Assumes: Command and bridge control enables arrive as levels from the command logic
// Notes:   Each decision is presented one cycle after its request, as a registered pulse

// Operation
// (RULE1) I/O enable clear: primary I/O transactions are never claimed.
// (RULE2) Master enable clear: secondary I/O and memory transactions are ignored.
// (RULE3) Primary I/O inside the window goes downstream.
// (RULE4) Secondary I/O outside the window goes upstream.
// (RULE5) Address passes unchanged; every non-downstream address counts as upstream.
// (RULE6) Base above limit disables window; all secondary I/O goes upstream.
// (RULE7) Window is 4 kB aligned, 4 kB granular, up to 4 GB.
// (RULE8) Base low byte: writable upper nibble is bits 15:12, low nibble reads 1.
// (RULE9) Base bits 11:0 are taken as zero.
// (RULE10) Base upper register, fully writable, supplies bits 31:16.
// (RULE11) Reset clears the whole 32-bit base.
// (RULE12) Limit low byte: writable upper nibble is bits 15:12, low nibble reads 1.
// (RULE13) Limit bits 11:0 are taken as all ones.
// (RULE14) Limit upper register, fully writable, supplies bits 31:16.
// (RULE15) Reset sets limit to cover the lowest 4 kB.
// (RULE16) ISA mode acts only in window with address bits 31:16 zero.
// (RULE17) ISA mode: only bottom 256 bytes per 1 kB below 64 kB go down.
// (RULE18) ISA mode: addresses at or above 64 kB use the plain window.
// (RULE19) ISA mode, master on: upper 768 bytes below 64 kB go upstream.
// (RULE20) ISA mode: other secondary I/O goes upstream only when outside window.
// (RULE21) Software programs window and ISA before enables, changes only when idle.
// (RULE22) Window test is inclusive over the full 32-bit address.
module iwfd_decode
   import iwfd_pkg::*;
(
   // Clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_I,
   // Command and bridge control enables
   input  wire logic        IO_EN_I,
   input  wire logic        MASTER_EN_I,
   input  wire logic        ISA_EN_I,
   // Configuration access from the primary bus
   input  wire logic        CFG_WR_I,
   input  wire logic        CFG_RD_I,
   input  wire logic [7:0]  CFG_ADDR_I,
   input  wire logic [3:0]  CFG_BE_I,
   input  wire logic [31:0] CFG_WDATA_I,
   output logic      [31:0] CFG_RDATA_O,
   output logic             CFG_RVALID_O,
   // Primary side I/O request and decision
   input  wire logic        P_IO_VALID_I,
   input  wire logic [31:0] P_IO_ADDR_I,
   output logic             P_DEC_VALID_O,
   output iwfd_dec_t        P_DEC_O,
   // Secondary side I/O request and decision
   input  wire logic        S_IO_VALID_I,
   input  wire logic [31:0] S_IO_ADDR_I,
   output logic             S_DEC_VALID_O,
   output iwfd_dec_t        S_DEC_O
);

   // ***************************************************************
   // Helper functions
   // ***************************************************************

   // Inclusive full-width compare; base above limit can never match
   function automatic logic in_window(input logic [31:0] a,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
      in_window = (a >= lo) && (a <= hi); // RULE22 RULE6 RULE7
   endfunction : in_window

   // Upper 768 bytes of a 1 kB block inside the first 64 kB
   function automatic logic isa_alias(input logic [31:0] a);
      isa_alias = (a[31:16] == IWFD_ISA_SEG_HIGH) && (a[9:8] != IWFD_ISA_LOW_QUAD); // RULE16
   endfunction : isa_alias

   // ***************************************************************
   // Window registers
   // ***************************************************************
   logic [3:0]  base_nib_q;
   logic [3:0]  base_nib_d;
   logic [3:0]  lim_nib_q;
   logic [3:0]  lim_nib_d;
   logic [15:0] base_hi_q;
   logic [15:0] base_hi_d;
   logic [15:0] lim_hi_q;
   logic [15:0] lim_hi_d;
   logic [31:0] base_addr;
   logic [31:0] lim_addr;
   logic        sel_low;
   logic        sel_high;

   // Dword decode of the two configuration words holding the window
   assign sel_low  = (CFG_ADDR_I[7:2] == IWFD_OFF_BASE_LOW[7:2]);
   assign sel_high = (CFG_ADDR_I[7:2] == IWFD_OFF_BASE_HIGH[7:2]);

   // Expanded window bounds
   assign base_addr = {base_hi_q, base_nib_q, IWFD_BASE_LOW_BITS};  // RULE9 RULE10
   assign lim_addr  = {lim_hi_q, lim_nib_q, IWFD_LIMIT_LOW_BITS};   // RULE13 RULE14

   // Byte-lane writes; the upper two bytes of the low dword are not ours and ignored
   always_comb begin
      base_nib_d = base_nib_q;
      lim_nib_d  = lim_nib_q;
      base_hi_d  = base_hi_q;
      lim_hi_d   = lim_hi_q;
      if (CFG_WR_I && sel_low) begin
         if (CFG_BE_I[IWFD_OFF_BASE_LOW[1:0]]) begin
            base_nib_d = CFG_WDATA_I[7:4]; // RULE8
         end
         if (CFG_BE_I[IWFD_OFF_LIMIT_LOW[1:0]]) begin
            lim_nib_d = CFG_WDATA_I[15:12]; // RULE12
         end
      end
      if (CFG_WR_I && sel_high) begin
         if (CFG_BE_I[0]) begin
            base_hi_d[7:0] = CFG_WDATA_I[7:0]; // RULE10
         end
         if (CFG_BE_I[1]) begin
            base_hi_d[15:8] = CFG_WDATA_I[15:8]; // RULE10
         end
         if (CFG_BE_I[2]) begin
            lim_hi_d[7:0] = CFG_WDATA_I[23:16]; // RULE14
         end
         if (CFG_BE_I[3]) begin
            lim_hi_d[15:8] = CFG_WDATA_I[31:24]; // RULE14
         end
      end
   end

   // Window state; reset gives the lowest 4 kB block
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         base_nib_q <= IWFD_BASE_RST[15:12];  // RULE11
         base_hi_q  <= IWFD_BASE_RST[31:16];  // RULE11
         lim_nib_q  <= IWFD_LIMIT_RST[15:12]; // RULE15
         lim_hi_q   <= IWFD_LIMIT_RST[31:16]; // RULE15
      end else begin
         base_nib_q <= base_nib_d;
         base_hi_q  <= base_hi_d;
         lim_nib_q  <= lim_nib_d;
         lim_hi_q   <= lim_hi_d;
      end
   end

   // ***************************************************************
   // Configuration read port
   // ***************************************************************
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        rvalid_q;
   logic        rvalid_d;

   // Unmapped dwords and foreign bytes read as zero
   always_comb begin
      rvalid_d = CFG_RD_I;
      rdata_d  = 32'h0000_0000;
      if (CFG_RD_I && sel_low) begin
         rdata_d = {16'h0000, lim_nib_q, IWFD_IO32_CODE, base_nib_q, IWFD_IO32_CODE}; // RULE8 RULE12
      end else if (CFG_RD_I && sel_high) begin
         rdata_d = {lim_hi_q, base_hi_q};
      end
   end

   // Read answer one cycle after the strobe
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         rdata_q  <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign CFG_RDATA_O  = rdata_q;
   assign CFG_RVALID_O = rvalid_q;

   // ***************************************************************
   // Forwarding decisions
   // ***************************************************************
   logic      p_in_win;
   logic      s_in_win;
   logic      p_down;
   logic      s_up;
   logic      p_vld_q;
   logic      p_vld_d;
   logic      s_vld_q;
   logic      s_vld_d;
   iwfd_dec_t p_dec_q;
   iwfd_dec_t p_dec_d;
   iwfd_dec_t s_dec_q;
   iwfd_dec_t s_dec_d;

   assign p_in_win = in_window(P_IO_ADDR_I, base_addr, lim_addr);
   assign s_in_win = in_window(S_IO_ADDR_I, base_addr, lim_addr);

   // Downstream: in window, trimmed to bottom 256 bytes per 1 kB below 64 kB under ISA
   assign p_down = IO_EN_I && p_in_win                         // RULE1 RULE3 RULE18
                   && !(ISA_EN_I && isa_alias(P_IO_ADDR_I));    // RULE16 RULE17
   // Upstream: complement of the window, plus ISA aliases, no gaps
   assign s_up   = MASTER_EN_I                                 // RULE2
                   && (!s_in_win                                // RULE4 RULE5 RULE6 RULE20
                       || (ISA_EN_I && isa_alias(S_IO_ADDR_I))); // RULE19

   // Address is carried through untranslated
   always_comb begin
      p_vld_d      = P_IO_VALID_I;
      s_vld_d      = S_IO_VALID_I;
      p_dec_d.fwd  = P_IO_VALID_I && p_down;
      p_dec_d.addr = P_IO_ADDR_I; // RULE5
      s_dec_d.fwd  = S_IO_VALID_I && s_up;
      s_dec_d.addr = S_IO_ADDR_I; // RULE5
   end

   // Registered decisions keep the compare off the output path
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         p_vld_q <= 1'b0;
         s_vld_q <= 1'b0;
         p_dec_q <= '0;
         s_dec_q <= '0;
      end else begin
         p_vld_q <= p_vld_d;
         s_vld_q <= s_vld_d;
         p_dec_q <= p_dec_d;
         s_dec_q <= s_dec_d;
      end
   end

   assign P_DEC_VALID_O = p_vld_q;
   assign P_DEC_O       = p_dec_q;
   assign S_DEC_VALID_O = s_vld_q;
   assign S_DEC_O       = s_dec_q;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   a_io_disable_block: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE1
      (P_IO_VALID_I && !IO_EN_I) |=> (P_DEC_VALID_O && !P_DEC_O.fwd))
      else $error("primary I/O claimed with I/O enable clear");

   a_master_off_ignore: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE2
      (S_IO_VALID_I && !MASTER_EN_I) |=> (S_DEC_VALID_O && !S_DEC_O.fwd))
      else $error("secondary I/O forwarded with master enable clear");

   a_down_in_window: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE3
      (P_IO_VALID_I && IO_EN_I && !ISA_EN_I && (P_IO_ADDR_I >= base_addr) && (P_IO_ADDR_I <= lim_addr))
      |=> P_DEC_O.fwd)
      else $error("in-window primary I/O not forwarded");

   a_addr_unchanged: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE5
      (P_IO_VALID_I && S_IO_VALID_I)
      |=> ((P_DEC_O.addr == $past(P_IO_ADDR_I)) && (S_DEC_O.addr == $past(S_IO_ADDR_I))))
      else $error("forwarded address altered");

   a_off_window_up: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE6
      (S_IO_VALID_I && MASTER_EN_I && (base_addr > lim_addr)) |=> S_DEC_O.fwd)
      else $error("disabled window did not send secondary I/O upstream");

   a_low_nibble_code: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE8
      (CFG_RD_I && (CFG_ADDR_I == IWFD_OFF_BASE_LOW))
      |=> (CFG_RVALID_O && (CFG_RDATA_O[3:0] == 4'h1) && (CFG_RDATA_O[11:8] == 4'h1)))
      else $error("base or limit low nibble not reading 1");

   a_reset_window: assert property (@(posedge SYS_CLK_I) // RULE11
      RST_I |=> ((base_addr == 32'h0000_0000) && (lim_addr == 32'h0000_0FFF)))
      else $error("window not at lowest 4 kB after reset");

   a_isa_block_down: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE17
      (P_IO_VALID_I && ISA_EN_I && (P_IO_ADDR_I[31:16] == 16'h0000) && (P_IO_ADDR_I[9:8] != 2'h0))
      |=> !P_DEC_O.fwd)
      else $error("ISA alias forwarded downstream");

   a_isa_high_plain: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE18
      (P_IO_VALID_I && IO_EN_I && ISA_EN_I && (P_IO_ADDR_I[31:16] != 16'h0000)
       && (P_IO_ADDR_I >= base_addr) && (P_IO_ADDR_I <= lim_addr)) |=> P_DEC_O.fwd)
      else $error("window above 64 kB altered by ISA mode");

   a_isa_alias_up: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE19
      (S_IO_VALID_I && MASTER_EN_I && ISA_EN_I && (S_IO_ADDR_I[31:16] == 16'h0000)
       && (S_IO_ADDR_I[9:8] != 2'h0)) |=> S_DEC_O.fwd)
      else $error("ISA alias not forwarded upstream");

   a_in_window_stay: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE20
      (S_IO_VALID_I && (S_IO_ADDR_I >= base_addr) && (S_IO_ADDR_I <= lim_addr)
       && !(ISA_EN_I && (S_IO_ADDR_I[31:16] == 16'h0000) && (S_IO_ADDR_I[9:8] != 2'h0)))
      |=> !S_DEC_O.fwd)
      else $error("in-window secondary I/O forwarded upstream");

   // Out-of-window secondary traffic must reach the primary bus
   a_up_out_window: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE4
      (S_IO_VALID_I && MASTER_EN_I && ((S_IO_ADDR_I < base_addr) || (S_IO_ADDR_I > lim_addr)))
      |=> S_DEC_O.fwd)
      else $error("out-of-window secondary I/O not forwarded upstream");

   // ISA mode only trims the window, it never widens it downstream
   a_isa_no_widen: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE16
      (P_IO_VALID_I && ISA_EN_I && ((P_IO_ADDR_I < base_addr) || (P_IO_ADDR_I > lim_addr)))
      |=> !P_DEC_O.fwd)
      else $error("out-of-window primary I/O claimed in ISA mode");

   // Full dword write lands in both upper halves
   a_high_write_land: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE10
      (CFG_WR_I && sel_high && (CFG_BE_I == 4'hF))
      |=> ({lim_hi_q, base_hi_q} == $past(CFG_WDATA_I)))
      else $error("upper base or limit write did not land");

endmodule : iwfd_decode

// File: verification/iwfd_master_model.sv
// Purpose: Behavioural primary and secondary I/O masters facing the decoder
// Assumes: One address phase per cycle per bus, driven 1 ns after the rising edge
// Notes:   Released address lines flip, so a stale address never looks live
module iwfd_master_model
   import iwfd_pkg::*;
(
   // Clock
   input  wire logic        clk_i,
   // Address phases on both buses
   output logic             p_valid_o,
   output logic [31:0]      p_addr_o,
   output logic             s_valid_o,
   output logic [31:0]      s_addr_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle buses at time zero
   initial begin
      p_valid_o = 1'b0;
      s_valid_o = 1'b0;
      p_addr_o  = 32'h0000_0000;
      s_addr_o  = 32'h0000_0000;
   end

   // One phase on each bus; back to back when called every cycle
   task automatic send(input logic [31:0] pa, input logic [31:0] sa);
      @(posedge clk_i);
      #1;
      p_valid_o = 1'b1;
      s_valid_o = 1'b1;
      p_addr_o  = pa;
      s_addr_o  = sa;
   endtask : send

   // Release both buses
   task automatic rest();
      @(posedge clk_i);
      #1;
      p_valid_o = 1'b0;
      s_valid_o = 1'b0;
      p_addr_o  = ~p_addr_o;
      s_addr_o  = ~s_addr_o;
   endtask : rest
endmodule : iwfd_master_model

// File: verification/io_window_forward_decode_tb.sv
// Purpose: Self-checking bench for the I/O window forward decoder
// Assumes: Expected decisions come from a bench model of the window registers
// Notes:   Drivers queue expectations, a negedge monitor compares answers
module io_window_forward_decode_tb
   import iwfd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, rst, io_en, m_en, isa_en, cfg_wr, cfg_rd, cfg_rvalid;
   logic [7:0]  cfg_addr;
   logic [3:0]  cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, p_addr, s_addr, base_m, limit_m, r;
   logic        p_valid, s_valid, p_dec_valid, s_dec_valid;
   iwfd_dec_t   p_dec, s_dec;
   iwfd_dec_t   p_q[$];
   iwfd_dec_t   s_q[$];
   logic [31:0] r_q[$];
   int          bad_count = 0;
   int          compares = 0;
   int          cycles = 0;

   iwfd_decode iwfd_decode_i (.SYS_CLK_I(clk), .RST_I(rst), .IO_EN_I(io_en), .MASTER_EN_I(m_en),
      .ISA_EN_I(isa_en), .CFG_WR_I(cfg_wr), .CFG_RD_I(cfg_rd), .CFG_ADDR_I(cfg_addr), .CFG_BE_I(cfg_be),
      .CFG_WDATA_I(cfg_wdata), .CFG_RDATA_O(cfg_rdata), .CFG_RVALID_O(cfg_rvalid),
      .P_IO_VALID_I(p_valid), .P_IO_ADDR_I(p_addr), .P_DEC_VALID_O(p_dec_valid), .P_DEC_O(p_dec),
      .S_IO_VALID_I(s_valid), .S_IO_ADDR_I(s_addr), .S_DEC_VALID_O(s_dec_valid), .S_DEC_O(s_dec));
   iwfd_master_model iwfd_master_model_i (.clk_i(clk), .p_valid_o(p_valid), .p_addr_o(p_addr),
      .s_valid_o(s_valid), .s_addr_o(s_addr));

   // ****************************************
   // Reference model and compares
   // ****************************************
   function automatic iwfd_dec_t want(input logic down, input logic [31:0] a);
      logic inwin;
      logic isa_hit;
      inwin = (a >= {base_m[31:12], 12'h000}) && (a <= {limit_m[31:12], 12'hFFF});
      isa_hit = isa_en && (a[31:16] == 16'h0000) && (a[9:8] != 2'h0);
      if (down)
         want = '{io_en && inwin && !isa_hit, a};
      else
         want = '{m_en && (!inwin || isa_hit), a};
   endfunction : want

   task automatic cmp_dec(input string n, input iwfd_dec_t e, input iwfd_dec_t s);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : cmp_dec

   task automatic cmp_data(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : cmp_data

   task automatic results();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results

   // ****************************************
   // Drivers
   // ****************************************
   task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge clk);
      #1;
      {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, d};
      if (a == IWFD_OFF_BASE_LOW && be[0]) base_m[15:12] = d[7:4];
      if (a == IWFD_OFF_BASE_LOW && be[1]) limit_m[15:12] = d[15:12];
      for (int i = 0; i < 4; i++) begin
         if (a == IWFD_OFF_BASE_HIGH && be[i] && i < 2) base_m[16 + 8 * i +: 8] = d[8 * i +: 8];
         if (a == IWFD_OFF_BASE_HIGH && be[i] && i > 1) limit_m[8 * i +: 8] = d[8 * i +: 8];
      end
      @(posedge clk);
      #1;
      cfg_wr = 1'b0;
      cfg_wdata = ~cfg_wdata;
   endtask : cfg_write

   task automatic cfg_read(input logic [7:0] a);
      @(posedge clk);
      #1;
      {cfg_rd, cfg_addr} = {1'b1, a};
      if (a == IWFD_OFF_BASE_LOW)
         r_q.push_back({16'h0000, limit_m[15:12], 4'h1, base_m[15:12], 4'h1});
      else if (a == IWFD_OFF_BASE_HIGH)
         r_q.push_back({limit_m[31:16], base_m[31:16]});
      else
         r_q.push_back(32'h0000_0000);
      @(posedge clk);
      #1;
      cfg_rd = 1'b0;
   endtask : cfg_read

   // Junk in read-only nibbles and foreign bytes must not stick
   task automatic setwin(input logic [31:0] b, input logic [31:0] l);
      r = $urandom;
      cfg_write(IWFD_OFF_BASE_LOW, 4'hF, {r[31:16], l[15:12], r[3:0], b[15:12], r[7:4]});
      cfg_write(IWFD_OFF_BASE_HIGH, 4'hF, {l[31:16], b[31:16]});
      cfg_read(IWFD_OFF_BASE_LOW);
      cfg_read(IWFD_OFF_BASE_HIGH);
   endtask : setwin

   // Window edges, ISA quads and 64 kB edge on both buses, back to back
   task automatic sweep();
      logic [31:0] lo;
      logic [31:0] hi;
      logic [31:0] t [12];
      lo = {base_m[31:12], 12'h000};
      hi = {limit_m[31:12], 12'hFFF};
      for (int k = 0; k < 8; k++) begin
         {io_en, m_en, isa_en} = k[2:0];
         t = '{lo - 1, lo, lo + 32'h100, lo + 32'h3FF, lo + 32'h400, hi, hi + 1, 32'hFFFF, 32'h10000,
               32'h300, $urandom, $urandom};
         for (int i = 0; i < 12; i++) begin
            p_q.push_back(want(1'b1, t[i]));
            s_q.push_back(want(1'b0, t[11 - i]));
            iwfd_master_model_i.send(t[i], t[11 - i]);
         end
         iwfd_master_model_i.rest();
      end
   endtask : sweep

   // Answers are settled by the falling edge
   always @(negedge clk) begin
      if (p_dec_valid === 1'b1) cmp_dec("p_dec", p_q.pop_front(), p_dec);
      if (s_dec_valid === 1'b1) cmp_dec("s_dec", s_q.pop_front(), s_dec);
      if (cfg_rvalid === 1'b1) cmp_data("cfg_rdata", r_q.pop_front(), cfg_rdata);
   end

   // Hang guard, well above the planned run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         bad_count++;
         results();
      end
   end

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      {rst, io_en, m_en, isa_en, cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {1'b1, 49'h0};
      void'($urandom(85));
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      base_m = 32'h0000_0000;
      limit_m = 32'h0000_0FFF;
      cfg_read(IWFD_OFF_BASE_LOW);
      cfg_read(IWFD_OFF_BASE_HIGH);
      cfg_read(8'h04);
      sweep();
      setwin(32'h0000_F000, 32'h0001_1FFF);
      sweep();
      setwin(32'h0001_0000, 32'h0000_F000);
      sweep();
      setwin(32'h0000_0000, 32'hFFFF_FFFF);
      sweep();
      cfg_write(IWFD_OFF_BASE_HIGH, 4'h3, $urandom);
      cfg_read(IWFD_OFF_BASE_HIGH);
      repeat (4) begin
         setwin($urandom, $urandom);
         sweep();
      end
      repeat (4) @(posedge clk);
      cmp_data("pending", 32'h0, p_q.size() + s_q.size() + r_q.size());
      results();
   end
endmodule : io_window_forward_decode_tb
